// *** rtl/rssa_pkg.sv ***
// Shared constants, register map and operation codes of the rotate, subtract and skip unit.
package rssa_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 5;
	localparam int BUS_W  = 32;
	localparam int FLAG_W = 6;
	localparam int OP_W   = 5;
	localparam int BSEL_W = 3;

	// Register byte offsets on the bus.
	localparam logic [ADDR_W-1:0] OFS_CMD  = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_WORK = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_MEM  = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_IMM  = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_FLAG = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_STAT = 5'h14;

	// Field positions in the command word.
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_BIT_LSB = 8;

	// Status register bits.
	localparam int STAT_BUSY  = 0;
	localparam int STAT_SKIP  = 1;
	localparam int STAT_DUMMY = 2;

	// Flag register bits.
	localparam int FLG_C  = 0;
	localparam int FLG_Z  = 1;
	localparam int FLG_AC = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_SC = 4;
	localparam int FLG_CZ = 5;

	localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
	localparam logic [FLAG_W-1:0] FLAG_RST = 6'h00;
	localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;
	localparam logic [DATA_W-1:0] ONE      = 8'h01;
	localparam logic [DATA_W-1:0] ZERO     = 8'h00;

	typedef enum logic [OP_W-1:0] {
		OP_NOP          = 5'b00000,
		OP_ROT_L        = 5'b00001,
		OP_ROT_L_W      = 5'b00010,
		OP_ROT_LC       = 5'b00011,
		OP_ROT_LC_W     = 5'b00100,
		OP_ROT_R        = 5'b00101,
		OP_ROT_R_W      = 5'b00110,
		OP_ROT_RC       = 5'b00111,
		OP_ROT_RC_W     = 5'b01000,
		OP_SUBB_MEM     = 5'b01001,
		OP_SUBB_IMM     = 5'b01010,
		OP_SUBB_TO_MEM  = 5'b01011,
		OP_SUB_MEM      = 5'b01100,
		OP_SUB_TO_MEM   = 5'b01101,
		OP_SUB_IMM      = 5'b01110,
		OP_DEC_SKIP     = 5'b01111,
		OP_DEC_SKIP_W   = 5'b10000,
		OP_SET_BYTE     = 5'b10001,
		OP_SET_BIT      = 5'b10010,
		OP_INC_SKIP     = 5'b10011,
		OP_INC_SKIP_W   = 5'b10100,
		OP_SKIP_BIT_NZ  = 5'b10101,
		OP_SKIP_BYTE_NZ = 5'b10110
	} rssa_op_type;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_EXEC  = 2'b01,
		ST_DUMMY = 2'b10
	} rssa_state_type;

	function automatic logic is_skip_op(input rssa_op_type op);
		is_skip_op = (op == OP_DEC_SKIP) || (op == OP_DEC_SKIP_W) ||
			(op == OP_INC_SKIP) || (op == OP_INC_SKIP_W) ||
			(op == OP_SKIP_BIT_NZ) || (op == OP_SKIP_BYTE_NZ);
	endfunction : is_skip_op

endpackage : rssa_pkg

// *** rtl/rssa_subtract.sv ***
// Eight-bit subtractor with borrow and the full arithmetic flag set.
`timescale 1ns/10ps
module rssa_subtract (
	input  wire logic [rssa_pkg::DATA_W-1:0] minuend,    // Working register value.
	input  wire logic [rssa_pkg::DATA_W-1:0] subtrahend, // Memory byte or immediate.
	input  wire logic                        borrow_in,  // Extra one to subtract.
	input  wire logic                        chain,      // Zero flag chains with previous.
	input  wire logic                        cz_in,      // Previous chained zero flag.
	output logic      [rssa_pkg::DATA_W-1:0] diff,       // Eight-bit difference.
	output logic      [rssa_pkg::FLAG_W-1:0] flags       // Resulting flags.
);

	logic [rssa_pkg::DATA_W:0] wide;
	logic [4:0]                low;
	logic                      wrap;

	always_comb
	begin
		wide = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
		low  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
		diff = wide[rssa_pkg::DATA_W-1:0];
		wrap = (minuend[7] ^ subtrahend[7]) & (diff[7] ^ minuend[7]);
		flags = rssa_pkg::FLAG_RST;
		// Carry means no borrow: a negative result clears it.
		flags[rssa_pkg::FLG_C]  = ~wide[rssa_pkg::DATA_W];
		flags[rssa_pkg::FLG_Z]  = (diff == rssa_pkg::ZERO);
		flags[rssa_pkg::FLG_AC] = ~low[4];
		flags[rssa_pkg::FLG_OV] = wrap;
		// The sign of the true result survives an overflow.
		flags[rssa_pkg::FLG_SC] = wrap ^ diff[7];
		// A multi-byte borrow chain is zero only if every byte was.
		flags[rssa_pkg::FLG_CZ] = chain ? ((diff == rssa_pkg::ZERO) & cz_in)
			: (diff == rssa_pkg::ZERO);
	end

endmodule : rssa_subtract

// *** rtl/rssa_top.sv ***
// Rotate, subtract, set and skip execution unit with an Avalon-MM register port.
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module rssa_top (
	input  wire logic                        ref_clk,     // Instruction clock.
	input  wire logic                        reset,       // Synchronous reset.
	input  wire logic [rssa_pkg::ADDR_W-1:0] address,     // Byte address.
	input  wire logic                        read,        // Read request.
	input  wire logic                        write,       // Write request.
	input  wire logic [rssa_pkg::BUS_W-1:0]  writedata,   // Write data.
	input  wire logic [3:0]                  byteenable,  // Write byte lanes.
	output logic      [rssa_pkg::BUS_W-1:0]  readdata,    // Read data.
	output logic                             waitrequest, // Request not yet taken.
	output logic                             busy,        // Instruction in progress.
	output logic                             dummy_slot,  // Dummy cycle of a skip.
	output logic                             skip_next,   // Last skip decision.
	output logic                             op_done      // Instruction finished.
);

	rssa_pkg::rssa_state_type state_q;
	rssa_pkg::rssa_op_type    op_q;
	logic [rssa_pkg::BSEL_W-1:0] bsel_q;
	logic [rssa_pkg::DATA_W-1:0] work_q;
	logic [rssa_pkg::DATA_W-1:0] mem_q;
	logic [rssa_pkg::DATA_W-1:0] imm_q;
	logic [rssa_pkg::FLAG_W-1:0] flags_q;
	logic [rssa_pkg::BUS_W-1:0]  rdata_q;
	logic                        ack_q;
	logic                        skip_q;
	logic                        done_q;
	logic                        req;
	logic                        acc_wr;
	logic                        exec;
	logic [rssa_pkg::DATA_W-1:0] sub_rhs;
	logic                        sub_borrow;
	logic                        sub_chain;
	logic [rssa_pkg::DATA_W-1:0] sub_diff;
	logic [rssa_pkg::FLAG_W-1:0] sub_flags;
	logic [rssa_pkg::DATA_W-1:0] work_d;
	logic [rssa_pkg::DATA_W-1:0] mem_d;
	logic [rssa_pkg::FLAG_W-1:0] flags_d;
	logic                        work_we;
	logic                        mem_we;
	logic                        skip_d;
	logic                        carry;
	function automatic logic hit(input logic [rssa_pkg::ADDR_W-1:0] adr,
		input logic [rssa_pkg::ADDR_W-1:0] ofs);
		hit = (adr == ofs);
	endfunction : hit
	function automatic logic [rssa_pkg::BUS_W-1:0] widen(input logic [rssa_pkg::DATA_W-1:0] v);
		widen = {24'h000000, v};
	endfunction : widen

	// Bus handshake: every read takes two cycles, a write at least two.
	// Writes wait while an instruction runs so that operands stay stable.
	assign req         = read | write;
	assign waitrequest = req & ~ack_q;
	assign acc_wr      = write & ack_q;
	assign exec        = (state_q == rssa_pkg::ST_EXEC);
	assign carry       = flags_q[rssa_pkg::FLG_C];

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q & ~(write & busy);
	end
	// Read data is captured one cycle ahead so it stands at the taking edge.
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			rdata_q <= 32'h00000000;
		else if (read & ~ack_q)
		begin
			if (hit(address, rssa_pkg::OFS_CMD))
				rdata_q <= {21'h000000, bsel_q, 3'h0, op_q};
			else if (hit(address, rssa_pkg::OFS_WORK))
				rdata_q <= widen(work_q);
			else if (hit(address, rssa_pkg::OFS_MEM))
				rdata_q <= widen(mem_q);
			else if (hit(address, rssa_pkg::OFS_IMM))
				rdata_q <= widen(imm_q);
			else if (hit(address, rssa_pkg::OFS_FLAG))
				rdata_q <= widen({2'b00, flags_q});
			else if (hit(address, rssa_pkg::OFS_STAT))
				rdata_q <= widen({5'h00, dummy_slot, skip_q, busy});
			else
				rdata_q <= 32'h00000000;
		end
	end

	assign readdata = rdata_q;
	// A command write with byte lane 0 enabled launches the instruction in the next cycle.
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			op_q   <= rssa_pkg::OP_NOP;
			bsel_q <= 3'h0;
		end
		else if (acc_wr && hit(address, rssa_pkg::OFS_CMD))
		begin
			if (byteenable[0])
				op_q <= rssa_pkg::rssa_op_type'(writedata[rssa_pkg::CMD_OP_LSB +: rssa_pkg::OP_W]);
			if (byteenable[1])
				bsel_q <= writedata[rssa_pkg::CMD_BIT_LSB +: rssa_pkg::BSEL_W];
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			state_q <= rssa_pkg::ST_IDLE;
		else
		begin
			case (state_q)
				rssa_pkg::ST_IDLE:
				begin
					if (acc_wr && hit(address, rssa_pkg::OFS_CMD) && byteenable[0])
						state_q <= rssa_pkg::ST_EXEC;
				end
				rssa_pkg::ST_EXEC:
				begin
					// The dummy slot stands whether or not the skip is taken.
					if (rssa_pkg::is_skip_op(op_q))
						state_q <= rssa_pkg::ST_DUMMY;
					else
						state_q <= rssa_pkg::ST_IDLE;
				end
				rssa_pkg::ST_DUMMY:
					state_q <= rssa_pkg::ST_IDLE;
				default:
					state_q <= rssa_pkg::ST_IDLE;
			endcase
		end
	end
	assign busy       = (state_q != rssa_pkg::ST_IDLE);
	assign dummy_slot = (state_q == rssa_pkg::ST_DUMMY);
	// Subtract operand and borrow selection.
	always_comb
	begin
		sub_rhs    = mem_q;
		sub_borrow = 1'b0;
		sub_chain  = 1'b0;
		case (op_q)
			rssa_pkg::OP_SUBB_MEM, rssa_pkg::OP_SUBB_TO_MEM:
			begin
				sub_borrow = ~carry;
				sub_chain  = 1'b1;
			end
			rssa_pkg::OP_SUBB_IMM:
			begin
				sub_rhs    = imm_q;
				sub_borrow = ~carry;
				sub_chain  = 1'b1;
			end
			rssa_pkg::OP_SUB_IMM:
				sub_rhs = imm_q;
			default:
				sub_rhs = mem_q;
		endcase
	end

	rssa_subtract u_subtract (
		.minuend    (work_q),
		.subtrahend (sub_rhs),
		.borrow_in  (sub_borrow),
		.chain      (sub_chain),
		.cz_in      (flags_q[rssa_pkg::FLG_CZ]),
		.diff       (sub_diff),
		.flags      (sub_flags)
	);
	// Operation decode; all results are one byte wide.
	always_comb
	begin
		work_d  = work_q;
		mem_d   = mem_q;
		flags_d = flags_q;
		work_we = 1'b0;
		mem_we  = 1'b0;
		skip_d  = 1'b0;
		case (op_q)
			rssa_pkg::OP_ROT_L:
			begin
				mem_d  = {mem_q[6:0], mem_q[7]};
				mem_we = 1'b1;
			end
			rssa_pkg::OP_ROT_L_W:
			begin
				work_d  = {mem_q[6:0], mem_q[7]};
				work_we = 1'b1;
			end
			rssa_pkg::OP_ROT_LC:
			begin
				mem_d  = {mem_q[6:0], carry};
				mem_we = 1'b1;
				flags_d[rssa_pkg::FLG_C] = mem_q[7];
			end
			rssa_pkg::OP_ROT_LC_W:
			begin
				work_d  = {mem_q[6:0], carry};
				work_we = 1'b1;
				flags_d[rssa_pkg::FLG_C] = mem_q[7];
			end
			rssa_pkg::OP_ROT_R:
			begin
				mem_d  = {mem_q[0], mem_q[7:1]};
				mem_we = 1'b1;
			end
			rssa_pkg::OP_ROT_R_W:
			begin
				work_d  = {mem_q[0], mem_q[7:1]};
				work_we = 1'b1;
			end
			rssa_pkg::OP_ROT_RC:
			begin
				mem_d  = {carry, mem_q[7:1]};
				mem_we = 1'b1;
				flags_d[rssa_pkg::FLG_C] = mem_q[0];
			end
			rssa_pkg::OP_ROT_RC_W:
			begin
				work_d  = {carry, mem_q[7:1]};
				work_we = 1'b1;
				flags_d[rssa_pkg::FLG_C] = mem_q[0];
			end
			rssa_pkg::OP_SUBB_MEM, rssa_pkg::OP_SUBB_IMM,
			rssa_pkg::OP_SUB_MEM, rssa_pkg::OP_SUB_IMM:
			begin
				work_d  = sub_diff;
				work_we = 1'b1;
				flags_d = sub_flags;
			end
			rssa_pkg::OP_SUBB_TO_MEM, rssa_pkg::OP_SUB_TO_MEM:
			begin
				mem_d   = sub_diff;
				mem_we  = 1'b1;
				flags_d = sub_flags;
			end
			rssa_pkg::OP_DEC_SKIP:
			begin
				mem_d  = mem_q - rssa_pkg::ONE;
				mem_we = 1'b1;
				skip_d = (mem_d == rssa_pkg::ZERO);
			end
			rssa_pkg::OP_DEC_SKIP_W:
			begin
				work_d  = mem_q - rssa_pkg::ONE;
				work_we = 1'b1;
				skip_d  = (work_d == rssa_pkg::ZERO);
			end
			rssa_pkg::OP_SET_BYTE:
			begin
				mem_d  = rssa_pkg::ALL_ONES;
				mem_we = 1'b1;
			end
			rssa_pkg::OP_SET_BIT:
			begin
				mem_d  = mem_q | (rssa_pkg::ONE << bsel_q);
				mem_we = 1'b1;
			end
			rssa_pkg::OP_INC_SKIP:
			begin
				mem_d  = mem_q + rssa_pkg::ONE;
				mem_we = 1'b1;
				skip_d = (mem_d == rssa_pkg::ZERO);
			end
			rssa_pkg::OP_INC_SKIP_W:
			begin
				work_d  = mem_q + rssa_pkg::ONE;
				work_we = 1'b1;
				skip_d  = (work_d == rssa_pkg::ZERO);
			end
			rssa_pkg::OP_SKIP_BIT_NZ:
				skip_d = mem_q[bsel_q];
			rssa_pkg::OP_SKIP_BYTE_NZ:
			begin
				// The byte is read and written back unchanged.
				mem_we = 1'b1;
				skip_d = (mem_q != rssa_pkg::ZERO);
			end
			default:
				skip_d = 1'b0;
		endcase
	end
	// Bus writes cannot meet an execute cycle: they are held off while busy.
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			work_q <= rssa_pkg::BYTE_RST;
		else if (exec && work_we)
			work_q <= work_d;
		else if (acc_wr && hit(address, rssa_pkg::OFS_WORK) && byteenable[0])
			work_q <= writedata[rssa_pkg::DATA_W-1:0];
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			mem_q <= rssa_pkg::BYTE_RST;
		else if (exec && mem_we)
			mem_q <= mem_d;
		else if (acc_wr && hit(address, rssa_pkg::OFS_MEM) && byteenable[0])
			mem_q <= writedata[rssa_pkg::DATA_W-1:0];
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			imm_q <= rssa_pkg::BYTE_RST;
		else if (acc_wr && hit(address, rssa_pkg::OFS_IMM) && byteenable[0])
			imm_q <= writedata[rssa_pkg::DATA_W-1:0];
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			flags_q <= rssa_pkg::FLAG_RST;
		else if (exec)
			flags_q <= flags_d;
		else if (acc_wr && hit(address, rssa_pkg::OFS_FLAG) && byteenable[0])
			flags_q <= writedata[rssa_pkg::FLAG_W-1:0];
	end
	// Skip decision holds until the next instruction executes.
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			skip_q <= 1'b0;
		else if (exec)
			skip_q <= skip_d;
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			done_q <= 1'b0;
		else
			done_q <= (exec && !rssa_pkg::is_skip_op(op_q)) || dummy_slot;
	end
	assign skip_next = skip_q;
	assign op_done   = done_q;

endmodule : rssa_top

// *** tb/rssa_monitor.sv ***
// Checker of skip timing, completion pulse and bus hold-off of the unit.
`timescale 1ns/10ps
module rssa_monitor (
	input wire logic        ref_clk,     // Clock.
	input wire logic        reset,       // Reset.
	input wire logic [4:0]  address,     // Address.
	input wire logic        read,        // Read.
	input wire logic        write,       // Write.
	input wire logic [31:0] writedata,   // Write data.
	input wire logic [3:0]  byteenable,  // Lanes.
	input wire logic [31:0] readdata,    // Read data.
	input wire logic        waitrequest, // Wait.
	input wire logic        busy,        // Busy.
	input wire logic        dummy_slot,  // Dummy cycle.
	input wire logic        skip_next,   // Skip decision.
	input wire logic        op_done      // Done pulse.
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	a_dummy_in_busy: assert property (dummy_slot |-> busy)
		else $error("dummy slot outside busy");
	a_dummy_then_done: assert property (dummy_slot |=> !busy && op_done)
		else $error("no completion after dummy slot");
	a_exec_length: assert property ($rose(busy) |-> !dummy_slot ##1 (!busy || dummy_slot))
		else $error("execution length wrong");
	a_done_on_fall: assert property ($fell(busy) |-> op_done)
		else $error("busy fell without done");
	a_done_single: assert property (op_done |=> !op_done)
		else $error("done longer than one cycle");
	a_done_after_busy: assert property (op_done |-> $past(busy) && !busy)
		else $error("done without preceding busy");
	a_write_held: assert property (busy && write |-> waitrequest)
		else $error("write taken while busy");
	a_first_wait: assert property ($rose(read || write) |-> waitrequest)
		else $error("access answered in first cycle");
	a_one_wait: assert property ((read || write) && waitrequest && !busy |=> !waitrequest)
		else $error("access not answered after one wait");
	a_skip_moment: assert property ($changed(skip_next) |-> dummy_slot || op_done)
		else $error("skip decision changed off its slot");
endmodule : rssa_monitor

bind rssa_top rssa_monitor u_mon (.ref_clk(ref_clk), .reset(reset), .address(address),
	.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
	.readdata(readdata), .waitrequest(waitrequest), .busy(busy), .dummy_slot(dummy_slot),
	.skip_next(skip_next), .op_done(op_done));

// *** tb/rssa_top_tb_top.sv ***
// Self-checking bench of the rotate, subtract and skip unit.
`timescale 1ns/10ps
module rssa_top_tb_top;
	logic        ref_clk, reset, read, write, waitrequest, busy, dummy_slot, skip_next, op_done;
	logic [4:0]  address;
	logic [31:0] writedata, readdata;
	logic [3:0]  byteenable;
	logic [31:0] exp_q[$];
	logic [4:0]  adr_q[$];
	int          err_count, checks, cyc, dones, seed;
	logic [7:0]  w, m, imm;
	logic [5:0]  f;
	logic [2:0]  bs;
	logic        sk;

	rssa_top dut (.ref_clk(ref_clk), .reset(reset), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .busy(busy), .dummy_slot(dummy_slot),
		.skip_next(skip_next), .op_done(op_done));

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic wrap_up;
		// A read that was noted but never answered is a mismatch too.
		if (exp_q.size() != 0)
		begin
			err_count++;
			$display("ERROR pending_reads expected 0 seen %0d", exp_q.size());
		end
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			wrap_up;
		end
	end

	always @(posedge ref_clk)
		if (op_done === 1'b1)
			dones++;

	// Read data is judged only at the accepting edge, where it is defined to stand.
	always @(posedge ref_clk)
		if (read && waitrequest === 1'b0)
		begin
			checks++;
			if (readdata !== exp_q[0])
			begin
				err_count++;
				$display("ERROR reg %h expected %h seen %h", adr_q[0], exp_q[0], readdata);
			end
			void'(exp_q.pop_front());
			void'(adr_q.pop_front());
		end

	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge ref_clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= 1'b1;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask : bus_wr

	task automatic chk(input logic [4:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		adr_q.push_back(a);
		@(posedge ref_clk);
		address <= a;
		read <= 1'b1;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		read <= 1'b0;
	endtask : chk

	task automatic model(input logic [4:0] op);
		logic [8:0] t;
		logic [4:0] h;
		logic [7:0] s, d;
		logic       b, ov;
		sk = 1'b0;
		s = (op == 5'd10 || op == 5'd14) ? imm : m;
		b = (op >= 5'd9 && op <= 5'd11) ? ~f[0] : 1'b0;
		t = {1'b0, w} - {1'b0, s} - {8'h00, b};
		h = {1'b0, w[3:0]} - {1'b0, s[3:0]} - {4'h0, b};
		d = t[7:0];
		ov = (w[7] ^ s[7]) & (w[7] ^ d[7]);
		case (op)
			5'd1: m = {m[6:0], m[7]};
			5'd2: w = {m[6:0], m[7]};
			5'd3: {f[0], m} = {m, f[0]};
			5'd4: {f[0], w} = {m, f[0]};
			5'd5: m = {m[0], m[7:1]};
			5'd6: w = {m[0], m[7:1]};
			5'd7: {m, f[0]} = {f[0], m};
			5'd8: {w, f[0]} = {f[0], m};
			5'd15: m = m - 8'h01;
			5'd16: w = m - 8'h01;
			5'd17: m = 8'hff;
			5'd18: m[bs] = 1'b1;
			5'd19: m = m + 8'h01;
			5'd20: w = m + 8'h01;
			default: ;
		endcase
		case (op)
			5'd15, 5'd19: sk = (m == 8'h00);
			5'd16, 5'd20: sk = (w == 8'h00);
			5'd21: sk = m[bs];
			5'd22: sk = (m != 8'h00);
			default: ;
		endcase
		if (op >= 5'd9 && op <= 5'd14)
		begin
			f = {(d == 8'h00) & ((op > 5'd11) | f[5]), ov ^ d[7], ov, ~h[4],
				d == 8'h00, ~t[8]};
			if (op == 5'd11 || op == 5'd13)
				m = d;
			else
				w = d;
		end
	endtask : model

	task automatic run_op(input logic [4:0] op);
		int n;
		n = dones;
		bus_wr(5'h04, {24'h0, w}, 4'h1);
		bus_wr(5'h08, {24'h0, m}, 4'h1);
		bus_wr(5'h0c, {24'h0, imm}, 4'h1);
		bus_wr(5'h10, {26'h0, f}, 4'h1);
		bus_wr(5'h00, {21'h0, bs, 3'h0, op}, 4'h3);
		// This write arrives after the execute cycle, while busy only for a skip; the operation has already used the old operand.
		bus_wr(5'h0c, {24'h0, ~imm}, 4'h1);
		model(op);
		chk(5'h00, {21'h0, bs, 3'h0, op});
		chk(5'h04, {24'h0, w});
		chk(5'h08, {24'h0, m});
		chk(5'h0c, {24'h0, ~imm});
		chk(5'h10, {26'h0, f});
		chk(5'h14, {29'h0, 1'b0, sk, 1'b0});
		checks++;
		if (dones !== n + 1)
		begin
			err_count++;
			$display("ERROR op_done expected %0d seen %0d", n + 1, dones);
		end
		// The skip output holds its decision until the next instruction executes.
		checks++;
		if (skip_next !== sk)
		begin
			err_count++;
			$display("ERROR skip_next expected %b seen %b", sk, skip_next);
		end
	endtask : run_op

	initial
	begin
		seed = 76296;
		reset = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 5'h00;
		writedata = 32'h0;
		byteenable = 4'h0;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		for (int i = 0; i < 7; i++)
			chk(5'(i * 4), 32'h0);
		bus_wr(5'h1c, 32'hffffffff, 4'hf);
		bus_wr(5'h04, 32'h5a, 4'h0);
		chk(5'h1c, 32'h0);
		chk(5'h04, 32'h0);
		for (int k = 0; k < 3; k++)
			for (int op = 0; op < 24; op++)
			begin
				w = 8'($random(seed));
				m = 8'($random(seed));
				imm = 8'($random(seed));
				f = 6'($random(seed));
				bs = 3'($random(seed));
				// First rounds force the zero and wrap boundaries that random data rarely hits.
				if (k == 0 && (op == 15 || op == 16))
					m = 8'h01;
				if (k == 0 && (op == 19 || op == 20))
					m = 8'hff;
				if (k == 1 && op > 8)
					m = w;
				run_op(5'(op));
			end
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		chk(5'h04, 32'h0);
		chk(5'h10, 32'h0);
		// Let the read checker judge the last answer before the verdict.
		repeat (2) @(posedge ref_clk);
		wrap_up;
	end
endmodule : rssa_top_tb_top
